//--- rtl/thr_pkg.sv
// Package of constants for the track/hold routing control block
package thr_pkg;

  // Register byte offsets
  localparam logic [11:0] THR_OFS_CTRL = 12'h000;
  localparam logic [11:0] THR_OFS_HCNT = 12'h004;
  localparam logic [11:0] THR_OFS_CHAN = 12'h008;
  localparam logic [11:0] THR_OFS_STAT = 12'h00C;

  // Control register field positions
  localparam int THR_CTRL_KIND_LSB = 0;
  localparam int THR_CTRL_SRC_LSB = 4;
  localparam int THR_CTRL_FWD_LSB = 8;
  localparam int THR_CTRL_TH_BIT = 12;

  // Channel register field positions
  localparam int THR_CHAN_SEL_LSB = 0;
  localparam int THR_CHAN_TEMP_BIT = 8;
  localparam int THR_CHAN_OUTEN_BIT = 9;
  localparam int THR_CHAN_BPOUT_BIT = 10;

  // Status register field positions
  localparam int THR_STAT_HOLD_BIT = 0;
  localparam int THR_STAT_CTR_BIT = 1;
  localparam int THR_STAT_BP_BIT = 2;
  localparam int THR_STAT_SRCERR_BIT = 3;
  localparam int THR_STAT_BPERR_BIT = 4;
  localparam int THR_STAT_CNT_LSB = 8;

  // Operation kind codes
  localparam logic [1:0] THR_KIND_NONE = 2'h0;
  localparam logic [1:0] THR_KIND_SINGLE = 2'h1;
  localparam logic [1:0] THR_KIND_SCAN = 2'h2;

  // Hold source codes
  localparam logic [1:0] THR_SRC_COUNTER = 2'h0;
  localparam logic [1:0] THR_SRC_EXTPIN = 2'h1;
  localparam logic [1:0] THR_SRC_BACKPLANE = 2'h2;

  // Forwarding codes
  localparam logic [1:0] THR_FWD_NONE = 2'h0;
  localparam logic [1:0] THR_FWD_BOARD = 2'h1;
  localparam logic [1:0] THR_FWD_BACKPLANE = 2'h2;

  // Reset values and hold count limit
  localparam logic [31:0] THR_CTRL_RST = 32'h0000_0000;
  localparam logic [8:0] THR_HCNT_RST = 9'h001;
  localparam logic [8:0] THR_HCNT_MAX = 9'h100;

  // Track/hold mode of the sampler
  typedef enum logic {THR_TRACK, THR_HOLD} thr_mode_e;

endpackage

//--- rtl/thr_edge.sv
// Rising edge detector for the selected hold source
`timescale 1ns/1ns
`default_nettype none
module thr_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  output logic rise
);
  typedef struct packed {
    logic prev;
  } thr_edge_s;

  thr_edge_s st, next_st;

  // Remember the level one cycle back
  always_comb begin
    next_st.prev = level;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = level & ~st.prev;
endmodule
`default_nettype wire

//--- rtl/thr_hold_cnt.sv
// Hold enable counter: counts module enablings down to the return to track
`timescale 1ns/1ns
`default_nettype none
module thr_hold_cnt import thr_pkg::*; #(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic enable_rise,
  output logic done,
  output logic [W-1:0] count
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } thr_cnt_s;

  thr_cnt_s st, next_st;

  // Load wins over a count in the same cycle, so a new interval starts afresh
  always_comb begin
    next_st = st;
    done = 1'b0;
    if (load) begin
      next_st.cnt = load_val;
    end else if (enable_rise && st.cnt != '0) begin
      next_st.cnt = st.cnt - W'(1);
      done = (st.cnt == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;
endmodule
`default_nettype wire

//--- rtl/thr_ctrl.sv
// Track/hold routing control: APB registers, source select, forwarding
`timescale 1ns/1ns
`default_nettype none
module thr_ctrl import thr_pkg::*; #(
  parameter int CHAN_W = 8,
  parameter int CNT_W = 9
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // System straps and link side
  input wire logic CABLED,
  input wire logic MUXED_TEMPERATURE_CONFIGURATION,
  input wire logic BOARD_COUNTER_OUT,
  input wire logic EXT_HOLD_TRIGGER_PIN_IN,
  input wire logic BP_TRIG_IN,
  input wire logic BP_TRIG_BUSY,
  input wire logic BP_OUT_BUSY,
  input wire logic MODULE_ENABLE,
  output logic BOARD_COUNTER_DRIVE,
  output logic BOARD_COUNTER_DRIVE_EN,
  output logic EXT_HOLD_TRIGGER_PIN_OUT,
  output logic EXT_HOLD_TRIGGER_PIN_OE,
  output logic BP_TRIG_OUT,
  output logic BP_TRIG_OE,
  output logic SCAN_TIMER_DRIVE,
  output logic COUNTER_RESERVED,
  output logic BP_TRIG_CLAIMED,
  output logic HOLD,
  output logic [CHAN_W-1:0] CHANNEL_SELECT,
  output logic TEMP_SENSOR_SELECT,
  output logic MODULE_OUTPUT_EN,
  output logic BP_ANALOG_OUT_EN,
  output logic BP_ANALOG_RELEASE
);
  typedef struct packed {
    logic [1:0] kind;
    logic [1:0] src;
    logic [1:0] fwd;
    logic th_cmd;
    logic [CNT_W-1:0] hcnt;
    logic [CHAN_W-1:0] chan;
    logic temp_sel;
    logic out_en;
    logic bp_out;
    logic src_err;
    logic bp_err;
    logic ctr_res;
    logic bp_claim;
    thr_mode_e mode;
    logic [31:0] rdata;
    logic bp_release;
  } thr_ctrl_s;

  thr_ctrl_s st, next_st;
  logic wr, rd;
  logic src_level, src_rise, cnt_done, hold_entry;
  logic [CNT_W-1:0] cnt_val;
  logic active;
  logic [1:0] w_kind, w_src, w_fwd;
  logic [CHAN_W-1:0] w_chan;

  // A transfer completes in its first access cycle; no wait states
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & PENABLE & ~PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign active = (st.kind != THR_KIND_NONE);
  assign w_kind = PWDATA[THR_CTRL_KIND_LSB +: 2];
  assign w_src = PWDATA[THR_CTRL_SRC_LSB +: 2];
  assign w_fwd = PWDATA[THR_CTRL_FWD_LSB +: 2];
  assign w_chan = PWDATA[THR_CHAN_SEL_LSB +: CHAN_W];

  // Selected hold source level
  always_comb begin
    unique case (st.src)
      THR_SRC_COUNTER: src_level = BOARD_COUNTER_OUT;
      THR_SRC_EXTPIN: src_level = EXT_HOLD_TRIGGER_PIN_IN;
      THR_SRC_BACKPLANE: src_level = BP_TRIG_IN;
      default: src_level = 1'b0;
    endcase
  end

  thr_edge u_edge (
    .clk(CLK),
    .rst(SYS_RST),
    .level(src_level),
    .rise(src_rise)
  );

  // Scan entry into hold reloads the enable counter
  assign hold_entry = (st.kind == THR_KIND_SCAN) && src_rise;

  thr_hold_cnt #(.W(CNT_W)) u_cnt (
    .clk(CLK),
    .rst(SYS_RST),
    .load(hold_entry),
    .load_val(st.hcnt),
    .enable_rise(MODULE_ENABLE && st.mode == THR_HOLD && st.kind == THR_KIND_SCAN),
    .done(cnt_done),
    .count(cnt_val)
  );

  // Register writes, configuration checks and track/hold state
  always_comb begin
    next_st = st;
    next_st.bp_release = 1'b0;
    if (wr) begin
      unique case (PADDR)
        THR_OFS_CTRL: begin
          next_st.kind = w_kind;
          next_st.th_cmd = PWDATA[THR_CTRL_TH_BIT];
          if (w_kind == THR_KIND_NONE) begin
            // Free everything; selections are not taken in this kind
            next_st.ctr_res = 1'b0;
            next_st.bp_claim = 1'b0;
            next_st.src_err = 1'b0;
            next_st.bp_err = 1'b0;
            next_st.mode = THR_TRACK;
          end else begin
            next_st.src = w_src;
            next_st.fwd = w_fwd;
            // Counter source needs a cable to a board
            next_st.src_err = (w_src == THR_SRC_COUNTER && !CABLED) ||
                              (w_src == 2'h3) || (w_kind == 2'h3);
            // Counter is reserved when the pin or, with a cable, the counter drives hold
            next_st.ctr_res = (w_src == THR_SRC_COUNTER && CABLED) ||
                              (w_src == THR_SRC_EXTPIN);
            // A second driver on the backplane line is refused
            if (w_fwd == THR_FWD_BACKPLANE && w_src != THR_SRC_BACKPLANE) begin
              next_st.bp_err = BP_TRIG_BUSY && !st.bp_claim;
              next_st.bp_claim = !(BP_TRIG_BUSY && !st.bp_claim);
            end else begin
              next_st.bp_err = 1'b0;
              next_st.bp_claim = 1'b0;
            end
          end
        end
        THR_OFS_HCNT: begin
          // Count 0 is out of range and clamps to 1; above 256 clamps to 256
          if (PWDATA[CNT_W-1:0] == '0) begin
            next_st.hcnt = CNT_W'(1);
          end else if (PWDATA[CNT_W-1:0] > THR_HCNT_MAX) begin
            next_st.hcnt = THR_HCNT_MAX;
          end else begin
            next_st.hcnt = PWDATA[CNT_W-1:0];
          end
        end
        THR_OFS_CHAN: begin
          // Setup releases the earlier backplane driver before taking it
          next_st.bp_release = PWDATA[THR_CHAN_BPOUT_BIT] && BP_OUT_BUSY;
          next_st.out_en = PWDATA[THR_CHAN_OUTEN_BIT];
          next_st.bp_out = PWDATA[THR_CHAN_BPOUT_BIT];
          if (&w_chan) begin
            next_st.temp_sel = MUXED_TEMPERATURE_CONFIGURATION;
            next_st.chan = st.chan;
          end else begin
            next_st.temp_sel = 1'b0;
            next_st.chan = w_chan;
          end
        end
        default: begin
        end
      endcase
    end
    // Track/hold state per operation kind
    if (st.kind == THR_KIND_SINGLE) begin
      // Command through the counter source, else follow source level
      if (st.src == THR_SRC_COUNTER) begin
        next_st.mode = st.th_cmd ? THR_HOLD : THR_TRACK;
      end else begin
        next_st.mode = src_level ? THR_HOLD : THR_TRACK;
      end
    end else if (st.kind == THR_KIND_SCAN) begin
      if (src_rise) begin
        next_st.mode = THR_HOLD;
      end else if (cnt_done) begin
        next_st.mode = THR_TRACK;
      end
    end else begin
      next_st.mode = THR_TRACK;
    end
    // Read data is registered for the access phase
    next_st.rdata = '0;
    if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        THR_OFS_CTRL: begin
          next_st.rdata[THR_CTRL_KIND_LSB +: 2] = st.kind;
          next_st.rdata[THR_CTRL_SRC_LSB +: 2] = st.src;
          next_st.rdata[THR_CTRL_FWD_LSB +: 2] = st.fwd;
          next_st.rdata[THR_CTRL_TH_BIT] = st.th_cmd;
        end
        THR_OFS_HCNT: next_st.rdata[CNT_W-1:0] = st.hcnt;
        THR_OFS_CHAN: begin
          next_st.rdata[THR_CHAN_SEL_LSB +: CHAN_W] = st.chan;
          next_st.rdata[THR_CHAN_TEMP_BIT] = st.temp_sel;
          next_st.rdata[THR_CHAN_OUTEN_BIT] = st.out_en;
          next_st.rdata[THR_CHAN_BPOUT_BIT] = st.bp_out;
        end
        THR_OFS_STAT: begin
          next_st.rdata[THR_STAT_HOLD_BIT] = (st.mode == THR_HOLD);
          next_st.rdata[THR_STAT_CTR_BIT] = st.ctr_res;
          next_st.rdata[THR_STAT_BP_BIT] = st.bp_claim;
          next_st.rdata[THR_STAT_SRCERR_BIT] = st.src_err;
          next_st.rdata[THR_STAT_BPERR_BIT] = st.bp_err;
          next_st.rdata[THR_STAT_CNT_LSB +: CNT_W] = cnt_val;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st <= '0;
      st.hcnt <= THR_HCNT_RST;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; forwarding is suppressed when the source already is the target
  always_comb begin
    BOARD_COUNTER_DRIVE_EN = active && st.fwd == THR_FWD_BOARD &&
                             st.src == THR_SRC_BACKPLANE;
    EXT_HOLD_TRIGGER_PIN_OE = active && st.fwd == THR_FWD_BOARD &&
                              st.src == THR_SRC_BACKPLANE;
    BP_TRIG_OE = active && st.bp_claim;
    // Scan timer follows the external pin while scanning from it
    SCAN_TIMER_DRIVE = st.kind == THR_KIND_SCAN && st.src == THR_SRC_EXTPIN &&
                       EXT_HOLD_TRIGGER_PIN_IN;
  end

  assign BOARD_COUNTER_DRIVE = src_level;
  assign EXT_HOLD_TRIGGER_PIN_OUT = src_level;
  assign BP_TRIG_OUT = src_level;
  assign COUNTER_RESERVED = active && st.ctr_res;
  assign BP_TRIG_CLAIMED = active && st.bp_claim;
  assign HOLD = (st.mode == THR_HOLD);
  assign CHANNEL_SELECT = st.chan;
  assign TEMP_SENSOR_SELECT = st.temp_sel;
  assign MODULE_OUTPUT_EN = st.out_en;
  assign BP_ANALOG_OUT_EN = st.bp_out && !st.bp_release;
  assign BP_ANALOG_RELEASE = st.bp_release;
  assign PRDATA = st.rdata;
endmodule
`default_nettype wire

//--- tb/thr_far.sv
// Far side model: board counter, front pin source, peer trigger line, scan controller
`timescale 1ns/1ns
`default_nettype none
module thr_far (
  input wire logic clk,
  input wire logic rst,
  input wire logic ctr_level,
  input wire logic ext_level,
  input wire logic peer_level,
  input wire logic entry,
  input wire logic ctr_drv,
  input wire logic ctr_en,
  input wire logic pin_drv,
  input wire logic pin_oe,
  input wire logic bp_drv,
  input wire logic bp_oe,
  output logic ctr_out,
  output logic pin_in,
  output logic bp_in,
  output logic mod_en
);
  // Shared lines: a driving block wins, otherwise the far source shows
  assign ctr_out = ctr_en ? ctr_drv : ctr_level;
  assign pin_in = pin_oe ? pin_drv : ext_level;
  // Peer stands off the trigger line while this block claims it
  assign bp_in = bp_oe ? bp_drv : peer_level;
  // One enable pulse per scan-list entry of this module
  always_ff @(posedge clk) begin
    mod_en <= !rst && entry;
  end
endmodule
`default_nettype wire

//--- tb/thr_ctrl_asserts.sv
// Port-level checker of the track/hold routing control block
`timescale 1ns/1ns
`default_nettype none
module thr_ctrl_chk (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic BP_TRIG_IN,
  input wire logic EXT_HOLD_TRIGGER_PIN_IN,
  input wire logic BOARD_COUNTER_DRIVE,
  input wire logic BOARD_COUNTER_DRIVE_EN,
  input wire logic EXT_HOLD_TRIGGER_PIN_OUT,
  input wire logic EXT_HOLD_TRIGGER_PIN_OE,
  input wire logic BP_TRIG_OE,
  input wire logic SCAN_TIMER_DRIVE,
  input wire logic COUNTER_RESERVED,
  input wire logic BP_ANALOG_RELEASE,
  input wire logic HOLD
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Bus answers at once and reads stay quiet outside the access cycle
  a_ready_zero_wait: assert property (PSEL && PENABLE |-> PREADY) else $error("ready low");
  a_rdata_idle: assert property (!(PSEL && PENABLE) |-> PRDATA == 32'h0000_0000)
    else $error("read data outside access");
  // Forwarding to counter output and front pin goes together, from the trigger line
  a_fwd_pair_en: assert property (BOARD_COUNTER_DRIVE_EN == EXT_HOLD_TRIGGER_PIN_OE)
    else $error("forward enables differ");
  a_fwd_pair_val: assert property (BOARD_COUNTER_DRIVE_EN |->
    BOARD_COUNTER_DRIVE == BP_TRIG_IN && EXT_HOLD_TRIGGER_PIN_OUT == BP_TRIG_IN)
    else $error("forwarded value wrong");
  a_fwd_one_dest: assert property (!(BP_TRIG_OE && BOARD_COUNTER_DRIVE_EN))
    else $error("two forward targets");
  a_scan_pin_drive: assert property (SCAN_TIMER_DRIVE |-> EXT_HOLD_TRIGGER_PIN_IN)
    else $error("scan timer not from pin");
  a_pin_reserves: assert property (SCAN_TIMER_DRIVE |-> COUNTER_RESERVED)
    else $error("pin source not reserving");
  a_bp_src_free: assert property (BOARD_COUNTER_DRIVE_EN |-> !COUNTER_RESERVED)
    else $error("counter reserved for backplane source");
  a_release_pulse: assert property (BP_ANALOG_RELEASE |=> !BP_ANALOG_RELEASE)
    else $error("release longer than a cycle");
  // Main scenarios reached
  c_hold_entry: cover property ($rose(HOLD));
  c_release: cover property (BP_ANALOG_RELEASE);
  c_forward: cover property (BOARD_COUNTER_DRIVE_EN && BOARD_COUNTER_DRIVE);
endmodule
bind thr_ctrl thr_ctrl_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PRDATA(PRDATA), .BP_TRIG_IN(BP_TRIG_IN),
  .EXT_HOLD_TRIGGER_PIN_IN(EXT_HOLD_TRIGGER_PIN_IN), .BOARD_COUNTER_DRIVE(BOARD_COUNTER_DRIVE),
  .BOARD_COUNTER_DRIVE_EN(BOARD_COUNTER_DRIVE_EN),
  .EXT_HOLD_TRIGGER_PIN_OUT(EXT_HOLD_TRIGGER_PIN_OUT),
  .EXT_HOLD_TRIGGER_PIN_OE(EXT_HOLD_TRIGGER_PIN_OE), .BP_TRIG_OE(BP_TRIG_OE),
  .SCAN_TIMER_DRIVE(SCAN_TIMER_DRIVE), .COUNTER_RESERVED(COUNTER_RESERVED),
  .BP_ANALOG_RELEASE(BP_ANALOG_RELEASE), .HOLD(HOLD));
`default_nettype wire

//--- tb/thr_ctrl_tb_top.sv
// Self-checking testbench of the track/hold routing control block
`timescale 1ns/1ns
`default_nettype none
module thr_ctrl_tb_top import thr_pkg::*;;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cabled = 1, muxed = 0;
  logic ctr_level = 0, ext_level = 0, peer_level = 0, entry = 0, bp_busy = 0, bpo_busy = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'h0000_001E;
  logic pready, ctr_out, pin_in, bp_in, mod_en, cdrv, cdrv_en, pdrv, poe, bdrv, boe;
  logic scan_drv, ctr_rsv, bp_clm, hold, tsel, oen, aoen, arel, b, seen;
  logic [7:0] chsel;
  int error_cnt = 0, compares = 0, i, j, n;
  always #5 clk = ~clk;
  thr_ctrl dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(),
    .CABLED(cabled), .MUXED_TEMPERATURE_CONFIGURATION(muxed), .BOARD_COUNTER_OUT(ctr_out),
    .EXT_HOLD_TRIGGER_PIN_IN(pin_in), .BP_TRIG_IN(bp_in), .BP_TRIG_BUSY(bp_busy),
    .BP_OUT_BUSY(bpo_busy), .MODULE_ENABLE(mod_en), .BOARD_COUNTER_DRIVE(cdrv),
    .BOARD_COUNTER_DRIVE_EN(cdrv_en), .EXT_HOLD_TRIGGER_PIN_OUT(pdrv),
    .EXT_HOLD_TRIGGER_PIN_OE(poe), .BP_TRIG_OUT(bdrv), .BP_TRIG_OE(boe),
    .SCAN_TIMER_DRIVE(scan_drv), .COUNTER_RESERVED(ctr_rsv), .BP_TRIG_CLAIMED(bp_clm),
    .HOLD(hold), .CHANNEL_SELECT(chsel), .TEMP_SENSOR_SELECT(tsel), .MODULE_OUTPUT_EN(oen),
    .BP_ANALOG_OUT_EN(aoen), .BP_ANALOG_RELEASE(arel));
  thr_far far (.clk(clk), .rst(rst), .ctr_level(ctr_level), .ext_level(ext_level),
    .peer_level(peer_level), .entry(entry), .ctr_drv(cdrv), .ctr_en(cdrv_en), .pin_drv(pdrv),
    .pin_oe(poe), .bp_drv(bdrv), .bp_oe(boe), .ctr_out(ctr_out), .pin_in(pin_in),
    .bp_in(bp_in), .mod_en(mod_en));
  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Control word: kind, hold source, forwarding, commanded state
  function automatic logic [31:0] ctl(input logic [1:0] k, s, f, input logic c);
    return {19'h0_0000, c, 2'h0, f, 2'h0, s, 2'h0, k};
  endfunction
  task chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer; the request holds until ready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    // Ready and read data are taken at the same rising edge, then released
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (k >= 50) error_cnt++;
    r = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask
  task final_report();
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #500000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    apb(0, THR_OFS_CTRL, 0);
    chk_word("ctrl", THR_CTRL_RST, r);
    apb(0, THR_OFS_HCNT, 0);
    chk_word("hcnt", 32'h0000_0001, r);
    apb(0, 12'h010, 0);
    chk_word("unmapped", 32'h0000_0000, r);
    // Single channel: counter source follows command, pin source follows level
    for (i = 0; i < 4; i++) begin
      b = rnd() >> 7;
      apb(1, THR_OFS_CTRL, ctl(THR_KIND_SINGLE, THR_SRC_COUNTER, THR_FWD_NONE, b));
      cyc(2);
      chk_bit("hold cmd", b, hold);
      chk_bit("ctr reserved", 1'h1, ctr_rsv);
    end
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SINGLE, THR_SRC_EXTPIN, THR_FWD_NONE, 1'h0));
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      ext_level <= rnd() >> 9;
      cyc(3);
      chk_bit("hold level", ext_level, hold);
      chk_bit("pin reserved", 1'h1, ctr_rsv);
    end
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SINGLE, THR_SRC_COUNTER, THR_FWD_BOARD, 1'h0));
    cyc(2);
    chk_bit("fwd to self", 1'h0, cdrv_en);
    // Counter source refused when not cabled; second trigger driver refused
    cabled <= 0;
    bp_busy <= 1;
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SINGLE, THR_SRC_COUNTER, THR_FWD_BACKPLANE, 1'h0));
    apb(0, THR_OFS_STAT, 0);
    chk_bit("src err", 1'h1, r[THR_STAT_SRCERR_BIT]);
    chk_bit("bp err", 1'h1, r[THR_STAT_BPERR_BIT]);
    cabled <= 1;
    bp_busy <= 0;
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SINGLE, THR_SRC_COUNTER, THR_FWD_BACKPLANE, 1'h0));
    cyc(2);
    chk_bit("bp oe", 1'h1, boe);
    chk_bit("bp claim", 1'h1, bp_clm);
    // Kind none frees everything and ignores source and forwarding
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_NONE, THR_SRC_BACKPLANE, THR_FWD_BOARD, 1'h1));
    cyc(2);
    chk_bit("freed claim", 1'h0, bp_clm);
    chk_bit("freed ctr", 1'h0, ctr_rsv);
    chk_bit("ignored fwd", 1'h0, cdrv_en);
    chk_bit("ignored oe", 1'h0, boe);
    // Hold count clamps at both ends
    apb(1, THR_OFS_HCNT, 0);
    apb(0, THR_OFS_HCNT, 0);
    chk_word("hcnt min", 32'h0000_0001, r);
    apb(1, THR_OFS_HCNT, 32'h0000_012C);
    apb(0, THR_OFS_HCNT, 0);
    chk_word("hcnt max", {23'h0, THR_HCNT_MAX}, r);
    // Scanning from the trigger line, forwarded to the board; last pass reuses the count
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SCAN, THR_SRC_BACKPLANE, THR_FWD_BOARD, 1'h0));
    for (i = 0; i < 4; i++) begin
      n = i == 0 ? 256 : i == 1 ? 1 : i == 2 ? rnd() % 4 + 2 : n;
      if (i < 3) apb(1, THR_OFS_HCNT, n);
      @(posedge clk);
      peer_level <= 1;
      cyc(3);
      chk_bit("hold edge", 1'h1, hold);
      chk_bit("fwd board", 1'h1, cdrv_en);
      chk_bit("fwd pin oe", 1'h1, poe);
      chk_bit("fwd value", 1'h1, pdrv);
      for (j = 1; j <= n; j++) begin
        @(posedge clk);
        entry <= 1;
        @(posedge clk);
        entry <= 0;
        cyc(2);
        chk_bit("hold count", j < n, hold);
      end
      @(posedge clk);
      peer_level <= 0;
      cyc(2);
    end
    // Pin source in scanning also paces the scan timer
    apb(1, THR_OFS_CTRL, ctl(THR_KIND_SCAN, THR_SRC_EXTPIN, THR_FWD_NONE, 1'h0));
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      ext_level <= i[0];
      cyc(1);
      chk_bit("scan timer", i[0], scan_drv);
    end
    // Channel setup, backplane hand-over and the temperature sensor
    muxed <= 1;
    apb(1, THR_OFS_CHAN, 32'h0000_0203);
    cyc(2);
    chk_word("channel", 32'h0000_0003, {24'h00_0000, chsel});
    chk_bit("out en", 1'h1, oen);
    bpo_busy <= 1;
    apb(1, THR_OFS_CHAN, 32'h0000_0603);
    seen = 0;
    repeat (4) begin
      @(negedge clk);
      seen = seen | arel;
    end
    chk_bit("release", 1'h1, seen);
    chk_bit("bp out en", 1'h1, aoen);
    apb(1, THR_OFS_CHAN, 32'h0000_02FF);
    cyc(2);
    chk_bit("temp sel", 1'h1, tsel);
    muxed <= 0;
    apb(1, THR_OFS_CHAN, 32'h0000_02FF);
    cyc(2);
    chk_bit("temp unmuxed", 1'h0, tsel);
    final_report();
  end
endmodule
`default_nettype wire
